//--- hdl/aidr_pkg.sv
package aidr_pkg;
	localparam int          AIDR_AXI_ADDR_W   = 8;
	localparam int          AIDR_NUM_SRC      = 3;
	// byte addresses of the register words
	localparam logic [7:0]  AIDR_OFS_ENCLR    = 8'h00;
	localparam logic [7:0]  AIDR_OFS_ENSET    = 8'h04;
	localparam logic [7:0]  AIDR_OFS_FLAG     = 8'h08;
	localparam logic [7:0]  AIDR_OFS_RESULT   = 8'h0C;
	localparam logic [7:0]  AIDR_OFS_CTRL     = 8'h10;
	// source bit positions in flag and enable words
	localparam int          AIDR_BIT_RESULT_READY = 0;
	localparam int          AIDR_BIT_WINHIT   = 1;
	localparam int          AIDR_BIT_OVERRUN  = 2;
	// control word fields
	localparam int          AIDR_CTRL_AVG_EN  = 0;
	localparam int          AIDR_CTRL_AVG_LSB = 1;
	localparam int          AIDR_CTRL_AVG_W   = 3;
	localparam int          AIDR_AVG_CNT_W    = 8;
	// reset values
	localparam logic [2:0]  AIDR_FLAG_RST     = 3'h0;
	localparam logic [2:0]  AIDR_EN_RST       = 3'h0;
	// bus responses
	localparam logic [1:0]  AIDR_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  AIDR_RESP_SLVERR  = 2'h2;
	// decoded register selector
	typedef enum logic [2:0] {
		AIDR_SEL_ENCLR,
		AIDR_SEL_ENSET,
		AIDR_SEL_FLAG,
		AIDR_SEL_RESULT,
		AIDR_SEL_CTRL,
		AIDR_SEL_NONE
	} aidr_sel_t;
endpackage

//--- hdl/aidr_top.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
module aidr_top import aidr_pkg::*; #(
	parameter int DATA_W       = 12,
	parameter bit COMBINED_IRQ = 1'b0
) (
	input  wire logic                       CLK,
	input  wire logic                       RESET,
	input  wire logic                       CE,
	input  wire logic                       CONV_DONE,
	input  wire logic [DATA_W-1:0]          CONV_DATA,
	input  wire logic                       WINDOW_MONITOR_HIT,
	input  wire logic [AIDR_AXI_ADDR_W-1:0] AWADDR,
	input  wire logic                       AWVALID,
	output logic                            AWREADY,
	input  wire logic [31:0]                WDATA,
	input  wire logic [3:0]                 WSTRB,
	input  wire logic                       WVALID,
	output logic                            WREADY,
	output logic [1:0]                      BRESP,
	output logic                            BVALID,
	input  wire logic                       BREADY,
	input  wire logic [AIDR_AXI_ADDR_W-1:0] ARADDR,
	input  wire logic                       ARVALID,
	output logic                            ARREADY,
	output logic [31:0]                     RDATA,
	output logic [1:0]                      RRESP,
	output logic                            RVALID,
	input  wire logic                       RREADY,
	output logic                            DMA_RESULT_READY,
	output logic [AIDR_NUM_SRC-1:0]         IRQ
);

	localparam int ACC_W = DATA_W + AIDR_AVG_CNT_W;

	if (DATA_W < 1 || DATA_W > 24) begin : g_bad_width
		$error("DATA_W must lie between 1 and 24");
	end

	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        aw_have;
		logic                        w_have;
		logic [AIDR_AXI_ADDR_W-1:0]  awaddr;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        arready;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
		logic [AIDR_NUM_SRC-1:0]     flag;
		logic [AIDR_NUM_SRC-1:0]     en;
		logic [AIDR_NUM_SRC-1:0]     irq;
		logic                        dma_req;
		logic [DATA_W-1:0]           result;
		logic                        avg_en;
		logic [AIDR_CTRL_AVG_W-1:0]  avg_log2;
		logic [AIDR_AVG_CNT_W-1:0]   avg_cnt;
		logic [ACC_W-1:0]            acc;
	} aidr_state_t;

	aidr_state_t st_q;
	aidr_state_t st_d;

	logic                    wr_do;
	logic                    rd_do;
	logic                    res_new;
	logic                    rd_result;
	logic [AIDR_NUM_SRC-1:0] flag_set;
	logic [AIDR_NUM_SRC-1:0] flag_clr;

	function automatic aidr_sel_t decode(input logic [AIDR_AXI_ADDR_W-1:0] addr);
		unique case (addr)
			AIDR_OFS_ENCLR:  decode = AIDR_SEL_ENCLR;
			AIDR_OFS_ENSET:  decode = AIDR_SEL_ENSET;
			AIDR_OFS_FLAG:   decode = AIDR_SEL_FLAG;
			AIDR_OFS_RESULT: decode = AIDR_SEL_RESULT;
			AIDR_OFS_CTRL:   decode = AIDR_SEL_CTRL;
			default:         decode = AIDR_SEL_NONE;
		endcase
	endfunction

	function automatic logic [AIDR_AVG_CNT_W-1:0] avg_last(input logic [AIDR_CTRL_AVG_W-1:0] n);
		avg_last = AIDR_AVG_CNT_W'((9'h001 << n) - 9'h001);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [ACC_W-1:0] sum;
		aidr_sel_t        wsel;
		aidr_sel_t        rsel;
		sum       = '0;
		wsel      = AIDR_SEL_NONE;
		rsel      = AIDR_SEL_NONE;
		st_d      = st_q;
		res_new   = 1'b0;
		rd_result = 1'b0;
		flag_set  = '0;
		flag_clr  = '0;

		// write side: address and data are caught in either order
		if (AWVALID && st_q.awready) begin
			st_d.aw_have = 1'b1;
			st_d.awaddr  = AWADDR;
		end
		if (WVALID && st_q.wready) begin
			st_d.w_have = 1'b1;
			st_d.wdata  = WDATA;
			st_d.wstrb  = WSTRB;
		end
		if (st_q.bvalid && BREADY) begin
			st_d.bvalid = 1'b0;
		end
		wr_do = st_q.aw_have && st_q.w_have && !st_q.bvalid;
		if (wr_do) begin
			wsel         = decode(st_q.awaddr);
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = (wsel == AIDR_SEL_NONE) ? AIDR_RESP_SLVERR : AIDR_RESP_OKAY;
			if (st_q.wstrb[0]) begin
				unique case (wsel)
					AIDR_SEL_ENCLR: st_d.en = st_q.en & ~st_q.wdata[AIDR_NUM_SRC-1:0];
					AIDR_SEL_ENSET: st_d.en = st_q.en | st_q.wdata[AIDR_NUM_SRC-1:0];
					AIDR_SEL_FLAG:  flag_clr = st_q.wdata[AIDR_NUM_SRC-1:0];
					AIDR_SEL_CTRL: begin
						st_d.avg_en   = st_q.wdata[AIDR_CTRL_AVG_EN];
						st_d.avg_log2 = st_q.wdata[AIDR_CTRL_AVG_LSB +: AIDR_CTRL_AVG_W];
						// a new setting restarts a half-finished average, unless a conversion lands in the same cycle and overwrites acc and avg_cnt
						st_d.avg_cnt  = '0;
						st_d.acc      = '0;
					end
					AIDR_SEL_RESULT, AIDR_SEL_NONE: ;
				endcase
			end
		end
		// a bus ready is low while a word is held or a response waits
		st_d.awready = !st_d.aw_have && !st_d.bvalid;
		st_d.wready  = !st_d.w_have && !st_d.bvalid;

		// read side
		if (st_q.rvalid && RREADY) begin
			st_d.rvalid = 1'b0;
		end
		rd_do = ARVALID && st_q.arready;
		if (rd_do) begin
			rsel        = decode(ARADDR);
			st_d.rvalid = 1'b1;
			st_d.rresp  = AIDR_RESP_OKAY;
			st_d.rdata  = '0;
			unique case (rsel)
				AIDR_SEL_ENCLR, AIDR_SEL_ENSET: st_d.rdata = 32'(st_q.en);
				AIDR_SEL_FLAG:   st_d.rdata = 32'(st_q.flag);
				AIDR_SEL_RESULT: begin
					st_d.rdata = 32'(st_q.result);
					rd_result  = 1'b1;
				end
				AIDR_SEL_CTRL:   st_d.rdata = 32'({st_q.avg_log2, st_q.avg_en});
				AIDR_SEL_NONE:   st_d.rresp = AIDR_RESP_SLVERR;
			endcase
		end
		st_d.arready = !st_d.rvalid;

		// conversion results and averaging
		if (CONV_DONE) begin
			if (!st_q.avg_en) begin
				st_d.result = CONV_DATA;
				res_new     = 1'b1;
			end else begin
				sum = st_q.acc + ACC_W'(CONV_DATA);
				if (st_q.avg_cnt == avg_last(st_q.avg_log2)) begin
					// only the finished average reaches the result register
					st_d.result  = DATA_W'(sum >> st_q.avg_log2);
					st_d.acc     = '0;
					st_d.avg_cnt = '0;
					res_new      = 1'b1;
				end else begin
					st_d.acc     = sum;
					st_d.avg_cnt = AIDR_AVG_CNT_W'(st_q.avg_cnt + 8'h01);
				end
			end
		end

		// a result that lands in the same cycle as the read keeps the request up
		if (rd_result) begin
			st_d.dma_req = 1'b0;
		end
		if (res_new) begin
			st_d.dma_req = 1'b1;
		end

		// overrun: a result replaces one that was never read
		flag_set[AIDR_BIT_RESULT_READY] = res_new;
		flag_set[AIDR_BIT_WINHIT]  = WINDOW_MONITOR_HIT;
		flag_set[AIDR_BIT_OVERRUN] = res_new && st_q.dma_req && !rd_result;
		// set beats clear so no event is lost
		st_d.flag = (st_q.flag & ~flag_clr) | flag_set;

		if (COMBINED_IRQ) begin
			st_d.irq = AIDR_NUM_SRC'(|(st_d.flag & st_d.en));
		end else begin
			st_d.irq = st_d.flag & st_d.en;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_q <= '0;
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	assign AWREADY          = st_q.awready;
	assign WREADY           = st_q.wready;
	assign BVALID           = st_q.bvalid;
	assign BRESP            = st_q.bresp;
	assign ARREADY          = st_q.arready;
	assign RVALID           = st_q.rvalid;
	assign RRESP            = st_q.rresp;
	assign RDATA            = st_q.rdata;
	assign DMA_RESULT_READY = st_q.dma_req;
	assign IRQ              = st_q.irq;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	chk_dma_direct_set: assert property (CE && CONV_DONE && !st_q.avg_en |=> DMA_RESULT_READY)
		else $error("result without averaging did not raise the dma request");

	chk_dma_read_drop: assert property (CE && rd_result && !res_new |=> !DMA_RESULT_READY)
		else $error("reading the result did not drop the dma request");

	chk_avg_midway: assert property (
		CE && CONV_DONE && st_q.avg_en && st_q.avg_cnt != avg_last(st_q.avg_log2) && !rd_result
		|=> $stable(DMA_RESULT_READY) && $stable(st_q.result))
		else $error("partial average changed the result or request");

	chk_flag_set_wm: assert property (CE && WINDOW_MONITOR_HIT |=> st_q.flag[AIDR_BIT_WINHIT])
		else $error("window hit did not set its flag");

	chk_overrun_set: assert property (CE && res_new && st_q.dma_req && !rd_result
		|=> st_q.flag[AIDR_BIT_OVERRUN] && st_q.flag[AIDR_BIT_RESULT_READY])
		else $error("unread result replaced without overrun flag");

	chk_en_set_bit: assert property (CE && wr_do && st_q.wstrb[0] && decode(st_q.awaddr) == AIDR_SEL_ENSET
		|=> (st_q.en & $past(st_q.wdata[AIDR_NUM_SRC-1:0])) == $past(st_q.wdata[AIDR_NUM_SRC-1:0])
		&& (st_q.en & ~$past(st_q.wdata[AIDR_NUM_SRC-1:0])) == ($past(st_q.en) & ~$past(st_q.wdata[AIDR_NUM_SRC-1:0])))
		else $error("enable set write misbehaved");

	chk_en_clr_bit: assert property (CE && wr_do && st_q.wstrb[0] && decode(st_q.awaddr) == AIDR_SEL_ENCLR
		|=> st_q.en == ($past(st_q.en) & ~$past(st_q.wdata[AIDR_NUM_SRC-1:0])))
		else $error("enable clear write misbehaved");

	chk_en_readback: assert property (CE && rd_do
		&& (decode(ARADDR) == AIDR_SEL_ENCLR || decode(ARADDR) == AIDR_SEL_ENSET) |=> RDATA == 32'($past(st_q.en)))
		else $error("enable register read did not return the enable mask");

	chk_irq_lines: assert property (
		COMBINED_IRQ ? (IRQ == AIDR_NUM_SRC'(|(st_q.flag & st_q.en))) : (IRQ == (st_q.flag & st_q.en)))
		else $error("interrupt lines differ from flag and enable");

	// one cycle ahead only: a write taken in this cycle may legally end the interrupt
	chk_irq_holds: assert property (!COMBINED_IRQ && IRQ[AIDR_BIT_WINHIT] && !(CE && wr_do)
		|=> IRQ[AIDR_BIT_WINHIT])
		else $error("interrupt dropped without clear, disable or reset");

	chk_dma_holds: assert property (DMA_RESULT_READY && !(CE && rd_result) |=> DMA_RESULT_READY)
		else $error("dma request dropped without a result read");

	chk_single_line: assert property (COMBINED_IRQ |-> IRQ[AIDR_NUM_SRC-1:1] == '0)
		else $error("combined mode drives more than one line");

	chk_flag_w1c: assert property (CE && wr_do && st_q.wstrb[0] && decode(st_q.awaddr) == AIDR_SEL_FLAG
		&& st_q.wdata[AIDR_BIT_WINHIT] && !WINDOW_MONITOR_HIT |=> !st_q.flag[AIDR_BIT_WINHIT])
		else $error("writing one did not clear the flag");

	chk_reset_clear: assert property ($fell(RESET) |-> st_q.flag == AIDR_FLAG_RST && st_q.en == AIDR_EN_RST)
		else $error("flags or enables not zero after reset");

	// both line modes run the same checks; the mode-only assertions test the build parameter first, cov_ovr_line does not and needs separate lines
	cov_avg_done:   cover property (CE && CONV_DONE && st_q.avg_en && res_new);
	cov_overrun:    cover property (CE && flag_set[AIDR_BIT_OVERRUN]);
	cov_irq_active: cover property (|IRQ ##1 IRQ == '0);
	cov_read_clear: cover property (DMA_RESULT_READY && CE && rd_result ##1 !DMA_RESULT_READY);
	cov_ovr_line:   cover property (IRQ[AIDR_BIT_OVERRUN]);

endmodule

//--- bench/aidr_far_end.sv
// stands in for the dma controller and the interrupt controller
module aidr_far_end (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       dma_req,
	input  wire logic [2:0] irq,
	output int              dma_rises,
	output int              irq_rises
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       dma_q;
	logic [2:0] irq_q;
	// counts edges only: a request left high is one transfer, not one per cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			{dma_q, irq_q} <= 4'h0;
			dma_rises <= 0;
			irq_rises <= 0;
		end else begin
			dma_q <= dma_req;
			irq_q <= irq;
			if (dma_req && !dma_q) dma_rises <= dma_rises + 1;
			if ((irq & ~irq_q) != 3'h0) irq_rises <= irq_rises + 1;
		end
	end
endmodule

//--- bench/aidr_top_tb.sv
module aidr_top_tb import aidr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset, ce, conv_done, win_hit, dma;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] conv_data;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [2:0]  irq, irq_c;
	int          compares, bad_count, dma_rises, irq_rises;
	////////////////////////////////////////////////////////////////
	aidr_top #(.DATA_W(12), .COMBINED_IRQ(1'b0)) dut (
		.CLK(clk), .RESET(reset), .CE(ce), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
		.WINDOW_MONITOR_HIT(win_hit), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .DMA_RESULT_READY(dma), .IRQ(irq));
	// shadow copy on the same bus, only its interrupt lines are watched
	aidr_top #(.DATA_W(12), .COMBINED_IRQ(1'b1)) dut_combined (
		.CLK(clk), .RESET(reset), .CE(ce), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
		.WINDOW_MONITOR_HIT(win_hit), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(), .BRESP(), .BVALID(),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(), .RDATA(),
		.RRESP(), .RVALID(), .RREADY(rready), .DMA_RESULT_READY(), .IRQ(irq_c));
	aidr_far_end far (.clk(clk), .reset(reset), .dma_req(dma), .irq(irq), .dma_rises(dma_rises),
		.irq_rises(irq_rises));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// a missing answer is reported as a mismatch and ends the run at once
	task automatic hang();
		chk(32'h0, 32'h1);
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		r = bresp;
		if (n == 40) hang();
	endtask
	task automatic wr0(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n == 40) hang();
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
	endtask
	// one-cycle event pulse, sampled just after the edge that takes it
	task automatic ev(input logic c, input logic w, input logic [11:0] v);
		@(posedge clk);
		{conv_done, win_hit} <= {c, w};
		conv_data <= v;
		@(posedge clk);
		{conv_done, win_hit} <= 2'b00;
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_result();
		int r0;
		r0 = irq_rises;
		rd_chk(AIDR_OFS_ENSET, 32'h0);
		rd_chk(AIDR_OFS_FLAG, 32'h0);
		wr0(AIDR_OFS_ENSET, 32'h7);
		rd_chk(AIDR_OFS_ENCLR, 32'h7);
		ev(1'b1, 1'b0, 12'hABC);
		chk(dma, 1'b1);
		chk({irq_c, irq}, 6'h09);
		rd_chk(AIDR_OFS_FLAG, 32'h1);
		rd_chk(AIDR_OFS_RESULT, 32'hABC);
		chk(dma, 1'b0);
		chk(irq, 3'h1);
		chk(irq_rises, r0 + 1);
		wr0(AIDR_OFS_FLAG, 32'h1);
		chk({irq_c, irq}, 6'h00);
		$display("test result done");
	endtask
	task automatic t_sources();
		wr0(AIDR_OFS_ENCLR, 32'h7);
		rd_chk(AIDR_OFS_ENSET, 32'h0);
		ev(1'b0, 1'b1, 12'h000);
		ev(1'b1, 1'b0, 12'h011);
		ev(1'b1, 1'b0, 12'h022);
		rd_chk(AIDR_OFS_FLAG, 32'h7);
		chk(irq, 3'h0);
		wr0(AIDR_OFS_ENSET, 32'h4);
		chk({irq_c, irq}, 6'h0C);
		wr0(AIDR_OFS_ENCLR, 32'h4);
		chk(irq, 3'h0);
		wr0(AIDR_OFS_ENSET, 32'h2);
		chk({irq_c, irq}, 6'h0A);
		wr0(AIDR_OFS_ENCLR, 32'h0);
		chk(irq, 3'h2);
		wr0(AIDR_OFS_FLAG, 32'h0);
		rd_chk(AIDR_OFS_FLAG, 32'h7);
		wr0(AIDR_OFS_ENCLR, 32'h2);
		chk(irq, 3'h0);
		wr0(AIDR_OFS_FLAG, 32'h7);
		rd_chk(AIDR_OFS_FLAG, 32'h0);
		rd_chk(AIDR_OFS_RESULT, 32'h022);
		$display("test sources done");
	endtask
	task automatic t_avg();
		int d0;
		d0 = dma_rises;
		wr0(AIDR_OFS_CTRL, 32'h5);
		rd_chk(AIDR_OFS_CTRL, 32'h5);
		ev(1'b1, 1'b0, 12'h001);
		ev(1'b1, 1'b0, 12'h002);
		ev(1'b1, 1'b0, 12'h003);
		chk(dma, 1'b0);
		ev(1'b1, 1'b0, 12'h006);
		chk(dma, 1'b1);
		rd_chk(AIDR_OFS_RESULT, 32'h003);
		chk(dma_rises, d0 + 1);
		wr0(AIDR_OFS_CTRL, 32'h0);
		$display("test averaging done");
	endtask
	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		rd(8'h14, d, r);
		chk(r, AIDR_RESP_SLVERR);
		chk(d, 32'h0);
		wr(8'h14, 32'h7, r);
		chk(r, AIDR_RESP_SLVERR);
		rd_chk(AIDR_OFS_ENSET, 32'h0);
		$display("test unmapped done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{reset, ce, wstrb} = 6'h3F;
		{conv_done, win_hit, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{conv_data, awaddr, araddr, wdata} = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_result();
		t_sources();
		t_avg();
		t_unmapped();
		close_out();
	end
endmodule
